// [design/saup_pkg.sv]
// constants shared by the stereo audio port design
// Notes on behaviour
// RL1 - The block holds two audio ports that run fully independently, each with its own clock, select and data lines.
// RL2 - A port in master mode drives bit clock and word select, and in slave mode takes both from the peer.
// RL3 - The serial data output is always driven as an output, whatever the mode.
// RL4 - Every channel word on the data lines is exactly 16 bits long.
// RL5 - Words go most significant bit first, with the left word's top bit in the first data slot of the frame.
// RL6 - The top bit of a new word leaves one bit clock after the word select change, launched on a falling edge.
// RL7 - The left word is sent while word select is low and the right word while it is high.
// RL8 - The peer captures our data on rising bit clock edges, since we change it only on falling edges.
// RL9 - One master setting gives 32 bit clocks per frame at 48 kHz, a 1.536 MHz bit clock.
// RL10 - The other master setting gives 50 bit clocks per frame at 48 kHz, a 2.400 MHz bit clock.
// RL11 - The master bit clock comes from the reference clock through a divider that multiplies by N and divides by M.
// RL12 - In slave mode the peer may use any bit clock up to 3.072 MHz.
// RL13 - The master bit clock keeps both its high and low phase at no less than 0.35 of the period.
// RL14 - In slave mode the peer keeps each bit clock phase at no less than 0.35 of the period.
// RL15 - Slots after the 16 data bits of a half frame are sent as zeros and ignored on receive.
package saup_pkg;
    localparam int unsigned CLK_HZ = 20000000; // reference clock, 50 ns period
    localparam int unsigned FRAME_HZ = 48000;
    localparam int unsigned WORD_BITS = 16;
    localparam int unsigned FRAME_BITS_A = 32; // 1.536 MHz setting
    localparam int unsigned FRAME_BITS_B = 50; // 2.400 MHz setting
    localparam int unsigned SLAVE_MAX_HZ = 3072000;
    localparam int unsigned PHASE_MIN_PCT = 35;
    // fractional divider: half-period ticks, step N against modulus M
    localparam int unsigned DIV_N_A = 2 * FRAME_HZ * FRAME_BITS_A;
    localparam int unsigned DIV_N_B = 2 * FRAME_HZ * FRAME_BITS_B;
    localparam int unsigned DIV_M = CLK_HZ;
    // bit slots per half frame
    localparam logic [5:0] HALF_A = 6'(FRAME_BITS_A / 2);
    localparam logic [5:0] HALF_B = 6'(FRAME_BITS_B / 2);
    localparam logic [5:0] WORD_SLOTS = 6'(WORD_BITS);
    localparam logic [5:0] CNT_MAX = 6'h3f;
    // least phase in clock cycles at the faster rate, rounded up
    localparam int unsigned BCLK_B_HZ = FRAME_HZ * FRAME_BITS_B;
    localparam int unsigned PHASE_MIN_CYC = (CLK_HZ / 100 * PHASE_MIN_PCT + BCLK_B_HZ - 1) / BCLK_B_HZ;
    localparam logic [15:0] WORD_RST = 16'h0000;
endpackage

// [design/saup_frac_div.sv]
// fractional n over m tick generator for the master bit clock
`timescale 1ns/1ns
module saup_frac_div
    import saup_pkg::*;
#(
    parameter int unsigned ACC_W = 32
) (
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // ratio
    input wire logic [ACC_W-1:0] step_n,
    input wire logic [ACC_W-1:0] mod_m,
    // half-period tick
    output logic tick
);
    typedef struct packed {
        logic [ACC_W-1:0] acc;
        logic tick;
    } saup_div_t;

    saup_div_t st_r;
    saup_div_t st_nxt;
    logic [ACC_W:0] sum;

    // add n every clock, wrap at m and emit a tick
    always_comb begin
        st_nxt = st_r;
        sum = {1'b0, st_r.acc} + {1'b0, step_n};
        st_nxt.tick = 1'b0;
        if (sum >= {1'b0, mod_m}) begin
            st_nxt.acc = ACC_W'(sum - {1'b0, mod_m}); // see RL11
            st_nxt.tick = 1'b1;
        end else begin
            st_nxt.acc = ACC_W'(sum);
        end
    end

    // state register
    always_ff @(posedge clock) begin
        if (reset) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign tick = st_r.tick;
endmodule

// [design/saup_top.sv]
// two independent stereo audio serial ports, master or slave each
`timescale 1ns/1ns
module saup_top
    import saup_pkg::*;
#(
    parameter int unsigned PORTS = 2
) (
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // per-port configuration
    input wire logic [PORTS-1:0] cfg_master,
    input wire logic [PORTS-1:0] cfg_rate50,
    // bit clock pin
    input wire logic [PORTS-1:0] sck_in,
    output logic [PORTS-1:0] sck_out,
    output logic [PORTS-1:0] sck_oe,
    // word select pin
    input wire logic [PORTS-1:0] ws_in,
    output logic [PORTS-1:0] ws_out,
    output logic [PORTS-1:0] ws_oe,
    // serial data pins
    output logic [PORTS-1:0] sdo,
    input wire logic [PORTS-1:0] sdi,
    // transmit words
    input wire logic [PORTS-1:0][15:0] tx_left,
    input wire logic [PORTS-1:0][15:0] tx_right,
    output logic [PORTS-1:0] tx_take,
    output logic [PORTS-1:0] tx_take_right,
    // received words
    output logic [PORTS-1:0][15:0] rx_data,
    output logic [PORTS-1:0] rx_right,
    output logic [PORTS-1:0] rx_valid
);
    typedef struct packed {
        logic master;
        logic rate50;
        logic sck;
        logic ws;
        logic sck_oe;
        logic ws_oe;
        logic sdo;
        logic [1:0] sck_sy;
        logic [1:0] ws_sy;
        logic [1:0] sdi_sy;
        logic sck_last;
        logic ws_seen;
        logic [5:0] cnt;
        logic [5:0] slot;
        logic [15:0] tx_word;
        logic [15:0] rx_sh;
        logic [15:0] rx_data;
        logic rx_right;
        logic rx_valid;
        logic tx_take;
        logic tx_take_right;
    } saup_port_t;

    typedef struct packed {
        saup_port_t [PORTS-1:0] p;
    } saup_state_t;

    saup_state_t st_r;
    saup_state_t st_nxt;
    logic [PORTS-1:0] tick;
    logic [PORTS-1:0] rise_ev;
    logic [PORTS-1:0] fall_ev;
    logic [PORTS-1:0] ws_now;

    // one divider per port so the ports never share timing
    genvar g;
    generate
        for (g = 0; g < PORTS; g++) begin : g_div
            saup_frac_div #( // see RL1
                .ACC_W(32)
            ) saup_frac_div_inst (
                .clock(clock),
                .reset(reset),
                .step_n(st_r.p[g].rate50 ? 32'(DIV_N_B) : 32'(DIV_N_A)), // see RL9 see RL10
                .mod_m(32'(DIV_M)),
                .tick(tick[g])
            );
            // bit clock edges from own divider or from the synchronised pin
            assign rise_ev[g] = st_r.p[g].master ? (tick[g] & ~st_r.p[g].sck)
                                                 : (st_r.p[g].sck_sy[1] & ~st_r.p[g].sck_last);
            assign fall_ev[g] = st_r.p[g].master ? (tick[g] & st_r.p[g].sck)
                                                 : (~st_r.p[g].sck_sy[1] & st_r.p[g].sck_last);
            assign ws_now[g] = st_r.p[g].master ? st_r.p[g].ws : st_r.p[g].ws_sy[1];
        end
    endgenerate

    // per-port serial engine
    always_comb begin
        logic [5:0] half;
        st_nxt = st_r;
        half = 6'h00;
        for (int i = 0; i < PORTS; i++) begin
            half = st_r.p[i].rate50 ? HALF_B : HALF_A;
            st_nxt.p[i].master = cfg_master[i];
            st_nxt.p[i].rate50 = cfg_rate50[i];
            st_nxt.p[i].sck_oe = st_r.p[i].master; // see RL2
            st_nxt.p[i].ws_oe = st_r.p[i].master; // see RL2
            // pin synchronisers, first stage only feeds the second
            st_nxt.p[i].sck_sy = {st_r.p[i].sck_sy[0], sck_in[i]};
            st_nxt.p[i].ws_sy = {st_r.p[i].ws_sy[0], ws_in[i]};
            st_nxt.p[i].sdi_sy = {st_r.p[i].sdi_sy[0], sdi[i]};
            st_nxt.p[i].sck_last = st_r.p[i].sck_sy[1];
            st_nxt.p[i].rx_valid = 1'b0;
            st_nxt.p[i].tx_take = 1'b0;
            if (!st_r.p[i].master) begin
                st_nxt.p[i].sck = 1'b0;
                st_nxt.p[i].slot = 6'h00;
            end
            // rising edge: sample data, detect word select change
            if (rise_ev[i]) begin
                if (st_r.p[i].master) begin
                    st_nxt.p[i].sck = 1'b1;
                end
                if (st_r.p[i].cnt < WORD_SLOTS) begin
                    st_nxt.p[i].rx_sh = {st_r.p[i].rx_sh[14:0], st_r.p[i].sdi_sy[1]}; // see RL15
                end
                st_nxt.p[i].ws_seen = ws_now[i];
                if (ws_now[i] != st_r.p[i].ws_seen) begin
                    // closing slot carries the old word's last bit when the half frame has 16 slots, else it is padding
                    if (st_r.p[i].cnt < WORD_SLOTS) begin
                        st_nxt.p[i].rx_data = {st_r.p[i].rx_sh[14:0], st_r.p[i].sdi_sy[1]};
                    end else begin
                        st_nxt.p[i].rx_data = st_r.p[i].rx_sh;
                    end
                    st_nxt.p[i].rx_right = st_r.p[i].ws_seen; // see RL7
                    st_nxt.p[i].rx_valid = 1'b1;
                    // next word: left while select low, right while high
                    st_nxt.p[i].tx_word = ws_now[i] ? tx_right[i] : tx_left[i]; // see RL7
                    st_nxt.p[i].tx_take = 1'b1;
                    st_nxt.p[i].tx_take_right = ws_now[i];
                    st_nxt.p[i].cnt = 6'h00;
                end else if (st_r.p[i].cnt != CNT_MAX) begin
                    st_nxt.p[i].cnt = st_r.p[i].cnt + 6'h01;
                end
            end
            // falling edge: launch data, master advances word select
            if (fall_ev[i]) begin
                if (st_r.p[i].master) begin
                    st_nxt.p[i].sck = 1'b0; // see RL13
                    if (st_r.p[i].slot >= half - 6'h01) begin
                        st_nxt.p[i].ws = ~st_r.p[i].ws; // see RL9 see RL10
                        st_nxt.p[i].slot = 6'h00;
                    end else begin
                        st_nxt.p[i].slot = st_r.p[i].slot + 6'h01;
                    end
                end
                if (st_r.p[i].cnt < WORD_SLOTS) begin
                    st_nxt.p[i].sdo = st_r.p[i].tx_word[4'(15 - st_r.p[i].cnt)]; // see RL5 see RL6 see RL4
                end else begin
                    st_nxt.p[i].sdo = 1'b0; // see RL15
                end
            end
        end
    end

    // state register
    always_ff @(posedge clock) begin
        if (reset) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from the state register
    generate
        for (g = 0; g < PORTS; g++) begin : g_out
            assign sck_out[g] = st_r.p[g].sck;
            assign sck_oe[g] = st_r.p[g].sck_oe;
            assign ws_out[g] = st_r.p[g].ws;
            assign ws_oe[g] = st_r.p[g].ws_oe;
            assign sdo[g] = st_r.p[g].sdo; // see RL3
            assign rx_data[g] = st_r.p[g].rx_data;
            assign rx_right[g] = st_r.p[g].rx_right;
            assign rx_valid[g] = st_r.p[g].rx_valid;
            assign tx_take[g] = st_r.p[g].tx_take;
            assign tx_take_right[g] = st_r.p[g].tx_take_right;
        end
    endgenerate

    // checks per port
    generate
        for (g = 0; g < PORTS; g++) begin : g_chk
            logic [7:0] phase_cnt;
            // cycles since the last master bit clock toggle
            always_ff @(posedge clock) begin
                if (reset || $changed(sck_out[g])) begin
                    phase_cnt <= 8'h01;
                end else if (phase_cnt != 8'hff) begin
                    phase_cnt <= phase_cnt + 8'h01;
                end
            end

            sdo_fall_only_a: assert property (@(posedge clock) disable iff (reset) // see RL8
                $changed(sdo[g]) |-> $past(fall_ev[g]))
                else $error("data output moved without a falling edge");

            msb_first_a: assert property (@(posedge clock) disable iff (reset) // see RL6
                (fall_ev[g] && st_r.p[g].cnt == 6'h00) |=> sdo[g] == $past(st_r.p[g].tx_word[15]))
                else $error("top bit not launched first after select change");

            last_bit_a: assert property (@(posedge clock) disable iff (reset) // see RL4
                (fall_ev[g] && st_r.p[g].cnt == 6'h0f) |=> sdo[g] == $past(st_r.p[g].tx_word[0]))
                else $error("bit sixteen is not the word's last bit");

            pad_zero_a: assert property (@(posedge clock) disable iff (reset) // see RL15
                (fall_ev[g] && st_r.p[g].cnt >= WORD_SLOTS) |=> !sdo[g])
                else $error("padding slot not zero");

            slave_release_a: assert property (@(posedge clock) disable iff (reset) // see RL2
                !cfg_master[g] ##1 !cfg_master[g] |=> !sck_oe[g] && !ws_oe[g])
                else $error("slave port drives clock or select");

            half_frame_a: assert property (@(posedge clock) disable iff (reset) // see RL9
                (st_r.p[g].master && $changed(ws_out[g]))
                |-> $past(st_r.p[g].slot) == (st_r.p[g].rate50 ? HALF_B : HALF_A) - 6'h01)
                else $error("word select toggled at wrong slot");

            phase_min_a: assert property (@(posedge clock) disable iff (reset) // see RL13
                (st_r.p[g].master && $past(st_r.p[g].master) && $changed(sck_out[g]) && $past(sck_oe[g])
                 && phase_cnt != 8'hff)
                |-> phase_cnt >= 8'(PHASE_MIN_CYC))
                else $error("bit clock phase too short");

            channel_side_a: assert property (@(posedge clock) disable iff (reset) // see RL7
                tx_take[g] |-> (tx_take_right[g] == ws_now[g]) && (rx_right[g] != ws_now[g]))
                else $error("channel does not match word select");
        end
    endgenerate
endmodule

// [testbench/saup_peer.sv]
// behavioural audio peer: captures serial words, sends words, times the bit clock
`timescale 1ns/1ns
module saup_peer #(
    parameter bit GEN = 0,
    parameter int HALF = 20,
    parameter int HALF_NS = 300
) (
    // wire levels
    input wire logic sck,
    input wire logic ws,
    input wire logic sdo,
    // driven lines
    output logic sck_g = 0,
    output logic ws_g = 0,
    output logic sdi = 0,
    // captured word
    output logic [15:0] cap_word,
    output logic cap_right,
    output logic cap_pad,
    output logic [5:0] cap_slots,
    output logic cap_tog = 0,
    // word sent
    output logic [15:0] ld_word,
    output logic ld_right,
    output logic ld_tog = 0,
    // clock timing in ns
    output int min_ph = 99999,
    output int frame_ns = 0
);
    logic wsl = 0;
    logic started = 0;
    logic pad = 0;
    logic load = 0;
    logic [15:0] sh = 16'h0000;
    logic [15:0] tx = 16'h0000;
    int cnt = 0;
    int tcnt = 16;
    int gen_n = 0;
    time te = 0;
    time tf = 0;
    // clock and select source, idle low unless this side is master
    initial if (GEN) forever begin
        #HALF_NS sck_g = 1;
        #HALF_NS sck_g = 0;
        gen_n = gen_n + 1;
        if (gen_n == HALF) begin
            gen_n = 0;
            ws_g = ~ws_g;
        end
    end
    // shortest phase and frame length
    always @(sck) begin
        if (started && int'($time - te) < min_ph) min_ph = int'($time - te);
        te = $time;
    end
    always @(posedge ws) begin
        if (tf != 0) frame_ns = int'($time - tf);
        tf = $time;
    end
    // capture on rising edges, msb first, padding collected apart
    always @(posedge sck) begin
        if (cnt < 16) sh = {sh[14:0], sdo};
        else pad = pad | sdo;
        cnt = cnt + 1;
        if (ws !== wsl) begin
            if (started) begin
                cap_word = sh;
                cap_right = wsl;
                cap_pad = pad;
                cap_slots = 6'(cnt);
                cap_tog = ~cap_tog;
            end
            started = 1;
            cnt = 0;
            pad = 0;
            wsl = ws;
            load = 1;
        end
    end
    // send on falling edges, junk in the slots past the word
    always @(negedge sck) begin
        if (load) begin
            tx = 16'($urandom);
            ld_word = tx;
            ld_right = wsl;
            ld_tog = ~ld_tog;
            tcnt = 0;
            load = 0;
        end
        sdi = (tcnt < 16) ? tx[15 - tcnt] : ~sdi;
        tcnt = tcnt + 1;
    end
endmodule

// [testbench/saup_top_bench.sv]
// self-checking bench: two master ports at both rates and one slave port
`timescale 1ns/1ns
module saup_top_bench;
    import saup_pkg::*;
    localparam int P = 3;
    localparam int HB [P] = '{16, 25, 20};
    logic clock = 0;
    logic reset = 1;
    logic [P-1:0] cfg_master = 3'h3;
    logic [P-1:0] cfg_rate50 = 3'h2;
    logic [P-1:0][15:0] tx_left = '0;
    logic [P-1:0][15:0] tx_right = '0;
    wire logic [P-1:0] sck_out, sck_oe, ws_out, ws_oe, sdo, sdi, sck_g, ws_g, sck_w, ws_w;
    wire logic [P-1:0] tx_take, tx_take_right, rx_right, rx_valid, cap_right, cap_pad, cap_tog, ld_right, ld_tog;
    wire logic [P-1:0][15:0] rx_data, cap_word, ld_word;
    wire logic [P-1:0][5:0] cap_slots;
    int min_ph [P];
    int frame_ns [P];
    int failures = 0;
    int comparisons = 0;
    int cycles = 0;
    logic [P-1:0] seen = '0;
    logic [16:0] rxq [P][$];
    logic [16:0] txq [P][$];
    // shared compare
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (exp !== got) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic stop_test();
        if (failures == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    always #25 clock = ~clock;
    // wire level from whoever drives
    assign sck_w = (sck_oe & sck_out) | (~sck_oe & sck_g);
    assign ws_w = (ws_oe & ws_out) | (~ws_oe & ws_g);
    // three ports at once, two masters at different rates and one slave
    saup_top #(.PORTS(P)) saup_top_inst (
        .clock(clock), .reset(reset), .cfg_master(cfg_master), .cfg_rate50(cfg_rate50),
        .sck_in(sck_w), .sck_out(sck_out), .sck_oe(sck_oe), .ws_in(ws_w), .ws_out(ws_out), .ws_oe(ws_oe),
        .sdo(sdo), .sdi(sdi), .tx_left(tx_left), .tx_right(tx_right), .tx_take(tx_take),
        .tx_take_right(tx_take_right), .rx_data(rx_data), .rx_right(rx_right), .rx_valid(rx_valid));
    for (genvar i = 0; i < P; i++) begin : g_port
        saup_peer #(.GEN(i == 2), .HALF(HB[i]), .HALF_NS(300)) saup_peer_inst (
            .sck(sck_w[i]), .ws(ws_w[i]), .sdo(sdo[i]), .sck_g(sck_g[i]), .ws_g(ws_g[i]), .sdi(sdi[i]),
            .cap_word(cap_word[i]), .cap_right(cap_right[i]), .cap_pad(cap_pad[i]), .cap_slots(cap_slots[i]),
            .cap_tog(cap_tog[i]), .ld_word(ld_word[i]), .ld_right(ld_right[i]), .ld_tog(ld_tog[i]),
            .min_ph(min_ph[i]), .frame_ns(frame_ns[i]));
        // notes of what should come out
        always @(ld_tog[i]) if ($time > 0) rxq[i].push_back({ld_right[i], ld_word[i]});
        always @(posedge clock) if (tx_take[i] === 1'b1) begin
            txq[i].push_back(tx_take_right[i] ? {1'b1, tx_right[i]} : {1'b0, tx_left[i]});
            #5 tx_left[i] = 16'($urandom);
            tx_right[i] = 16'($urandom);
        end
        // compare against the oldest note
        always @(cap_tog[i]) if ($time > 0) begin
            if (txq[i].size() > 0) check("tx word", txq[i].pop_front(), {cap_right[i], cap_word[i]});
            else check("tx count", 1, 0);
            check("slots", HB[i], cap_slots[i]);
            check("pad", 0, cap_pad[i]);
        end
        always @(posedge clock) if (rx_valid[i] === 1'b1) begin
            if (seen[i] && rxq[i].size() > 0) check("rx word", rxq[i].pop_front(), {rx_right[i], rx_data[i]});
            else if (seen[i]) check("rx count", 1, 0);
            seen[i] = 1;
        end
    end
    // hang guard
    always @(posedge clock) begin
        cycles++;
        if (cycles == 6000) begin
            failures++;
            stop_test();
        end
    end
    initial begin
        void'($urandom(32'he17ce67c));
        #5 tx_left = {16'($urandom), 16'($urandom), 16'($urandom)};
        tx_right = {16'($urandom), 16'($urandom), 16'($urandom)};
        repeat (4) @(posedge clock);
        #5 reset = 0;
        repeat (4) @(posedge clock);
        check("sck_oe", 3'h3, sck_oe);
        check("ws_oe", 3'h3, ws_oe);
        check("sdo", 0, ^sdo === 1'bx);
        repeat (4000) @(posedge clock);
        for (int i = 0; i < 2; i++) begin
            check("frame", 1, frame_ns[i] >= 20800 && frame_ns[i] <= 20850);
            check("phase", 1, 64'(min_ph[i]) * 9600000 * HB[i] >= 64'd35000000000);
        end
        for (int i = 0; i < P; i++) check("left", 1, rxq[i].size() <= 1 && txq[i].size() <= 1);
        stop_test();
    end
endmodule
